/* src/lscu_pkg.sv */
// Shared constants and types of the list sequence command unit
package lscu_pkg;
   localparam int DATA_W = 16;
   localparam int LOC_W = 10;
   localparam int SEQ_W = 9;
   localparam logic [LOC_W-1:0] DATA_DEPTH_M1 = 10'h3e9;
   localparam logic [10:0] DATA_DEPTH = 11'h3ea;
   localparam logic [9:0] SEQ_DEPTH = 10'h200;
   localparam logic [LOC_W-1:0] PTR_MAX = 10'h3e9;
   localparam logic [4:0] RB_COUNT = 5'h10;
   localparam logic [DATA_W-1:0] CURRENT_SETPOINT_QUARTER = 16'h3fff;
   localparam logic [15:0] ERR_CONFLICT = 16'hff23;
   localparam logic [15:0] ERR_RANGE = 16'hff22;
   localparam logic [15:0] ERR_COMMAND = 16'hff9c;
   localparam logic [LOC_W-1:0] RESET_PTR = 10'h000;
   typedef enum logic [3:0] {
      LSCU_CMD_NONE,
      LSCU_CMD_ORDER_SET,
      LSCU_CMD_ORDER_GET,
      LSCU_CMD_RBPTR_SET,
      LSCU_CMD_RBPTR_GET,
      LSCU_CMD_SEQ_ADD,
      LSCU_CMD_SEQ_GET,
      LSCU_CMD_VOLT_ADD,
      LSCU_CMD_VOLT_GET,
      LSCU_CMD_VOLT_COUNT,
      LSCU_CMD_CLEAR,
      LSCU_CMD_CURRENT_SETPOINT_SET,
      LSCU_CMD_RUN,
      LSCU_CMD_STOP
   } lscu_cmd_t;
endpackage

/* src/lscu_store.sv */
// Voltage data table and custom order table with one-cycle read
`timescale 1ns/10ps
module lscu_store (
   input wire logic clk_i,          // System clock
   lscu_tbl_if.store tbl            // Table access
);
   logic [lscu_pkg::DATA_W-1:0] volt_mem [0:1001];
   logic [lscu_pkg::LOC_W-1:0] seq_mem [0:511];
   logic [lscu_pkg::DATA_W-1:0] rdata_r;

   always_ff @(posedge clk_i) begin
      if (tbl.we && tbl.sel_seq) begin
         seq_mem[tbl.waddr[lscu_pkg::SEQ_W-1:0]] <=
            tbl.wdata[lscu_pkg::LOC_W-1:0];
      end else if (tbl.we) begin
         volt_mem[tbl.waddr] <= tbl.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (tbl.rsel_seq) begin
         rdata_r <= {6'h00, seq_mem[tbl.raddr[lscu_pkg::SEQ_W-1:0]]};
      end else begin
         rdata_r <= volt_mem[tbl.raddr];
      end
   end

   assign tbl.rdata = rdata_r;
endmodule // lscu_store

/* src/lscu_tbl_if.sv */
// Interface between the command unit and its table store
`timescale 1ns/10ps
interface lscu_tbl_if;
   logic we;
   logic sel_seq;
   logic [lscu_pkg::LOC_W-1:0] waddr;
   logic [lscu_pkg::DATA_W-1:0] wdata;
   logic [lscu_pkg::LOC_W-1:0] raddr;
   logic rsel_seq;
   logic [lscu_pkg::DATA_W-1:0] rdata;
   modport ctrl (output we, sel_seq, waddr, wdata, raddr, rsel_seq,
      input rdata);
   modport store (input we, sel_seq, waddr, wdata, raddr, rsel_seq,
      output rdata);
endinterface

/* src/lscu_top.sv */
// List sequence command unit: tables, pointers, checks and stepping
// Behaviour
// - Order setting holds natural or custom step order.
// - Natural order walks locations 0 to last filled, or reverse.
// - Custom order walks up to 512 sequence entries, honouring direction.
// - Order query returns the token matching the current setting.
// - Readback start pointer accepts 0 to 1001.
// - Pointer query returns it; it serves every table readback.
// - Sequence values fill successive cells from location 0.
// - Sequence table holds at most 512 entries; excess entries are dropped.
// - Sequence entries may name any location, repeats allowed.
// - Sequence readback gives up to 16 entries from the pointer.
// - Voltage values append at next free location; 1002 maximum.
// - List clear returns the fill location to 0.
// - With current entries, voltage append/readback/count give -221.
// - Voltage readback gives up to 16 values from the pointer.
// - Fill pointer clears on reset or clear, counts appends.
// - Count query returns the fill pointer, 0 to 1002.
// - Quarter range rejects setpoints above quarter maximum with -222.
// - While executing, list configuration commands give a command error.
`timescale 1ns/10ps
module lscu_top (
   input wire logic clk_i,                        // 50 MHz clock
   input wire logic rst_n_i,                      // Sync reset, low
   input wire lscu_pkg::lscu_cmd_t cmd_i,         // Parsed command code
   input wire logic cmd_valid_i,                  // Command strobe
   input wire logic [15:0] cmd_arg_i,             // Command argument
   input wire logic current_setpoint_list_used_i,             // Current list filled
   input wire logic current_setpoint_quarter_i,               // Quarter current range
   input wire logic dir_down_i,                   // Run in reverse
   input wire logic step_i,                       // Dwell expired pulse
   output logic custom_order_o,                   // Order: 1 custom
   output logic [9:0] rb_ptr_o,                   // Readback start pointer
   output logic [10:0] fill_cnt_o,                // Voltage fill count
   output logic [9:0] seq_cnt_o,                  // Sequence fill count
   output logic [15:0] resp_data_o,               // Response word
   output logic resp_valid_o,                     // Response strobe
   output logic resp_last_o,                      // Last response word
   output logic [15:0] err_code_o,                // Queued error code
   output logic err_valid_o,                      // Error strobe
   output logic [15:0] current_setpoint_set_o,                // Current setpoint
   output logic [15:0] level_o,                   // Output level
   output logic running_o                         // List executing
);
   typedef enum {LSCU_IDLE, LSCU_RB, LSCU_FETCH, LSCU_MAP, LSCU_LOAD,
      LSCU_DATA} lscu_st_t;
   lscu_st_t st_r;
   lscu_tbl_if tbl ();
   logic custom_r;
   logic [9:0] rbptr_r;
   logic [10:0] fill_r;
   logic [9:0] seqn_r;
   logic [4:0] rb_left_r;
   logic [9:0] rb_addr_r;
   logic rb_seq_r;
   logic rb_pend_r;
   logic [9:0] step_r;
   logic running_r;
   logic [15:0] current_setpoint_r;
   logic [15:0] level_r;
   logic [15:0] resp_r;
   logic resp_v_r;
   logic resp_l_r;
   logic [15:0] err_r;
   logic err_v_r;
   logic cfg_cmd;
   logic take;
   logic volt_blk;
   logic [9:0] last_idx;
   logic [10:0] rb_lim;

   lscu_store u_store (
      .clk_i (clk_i),
      .tbl (tbl.store)
   );

   ////////////////////////////////////////////////////////////////////////
   // Command acceptance and error checks
   assign cfg_cmd = cmd_valid_i && cmd_i != lscu_pkg::LSCU_CMD_NONE &&
      cmd_i != lscu_pkg::LSCU_CMD_STOP && cmd_i != lscu_pkg::LSCU_CMD_CURRENT_SETPOINT_SET;
   // Readbacks are one at a time; new commands wait in the host parser
   assign take = cmd_valid_i && !running_r && st_r == LSCU_IDLE;
   assign volt_blk = current_setpoint_list_used_i &&
      (cmd_i == lscu_pkg::LSCU_CMD_VOLT_ADD ||
       cmd_i == lscu_pkg::LSCU_CMD_VOLT_GET ||
       cmd_i == lscu_pkg::LSCU_CMD_VOLT_COUNT);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         err_r <= 16'h0000;
         err_v_r <= 1'b0;
      end else begin
         err_v_r <= 1'b0;
         if (running_r && cfg_cmd) begin
            err_r <= lscu_pkg::ERR_COMMAND;
            err_v_r <= 1'b1;
         end else if (take && volt_blk) begin
            err_r <= lscu_pkg::ERR_CONFLICT;
            err_v_r <= 1'b1;
         end else if (cmd_valid_i && cmd_i == lscu_pkg::LSCU_CMD_CURRENT_SETPOINT_SET &&
               current_setpoint_quarter_i && cmd_arg_i > lscu_pkg::CURRENT_SETPOINT_QUARTER) begin
            err_r <= lscu_pkg::ERR_RANGE;
            err_v_r <= 1'b1;
         end else if (take && cmd_i == lscu_pkg::LSCU_CMD_RBPTR_SET &&
               cmd_arg_i > {6'h00, lscu_pkg::PTR_MAX}) begin
            err_r <= lscu_pkg::ERR_RANGE;
            err_v_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Settings
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         custom_r <= 1'b0;
      end else if (take && cmd_i == lscu_pkg::LSCU_CMD_ORDER_SET) begin
         custom_r <= cmd_arg_i[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rbptr_r <= lscu_pkg::RESET_PTR;
      end else if (take && cmd_i == lscu_pkg::LSCU_CMD_CLEAR) begin
         rbptr_r <= lscu_pkg::RESET_PTR;
      end else if (take && cmd_i == lscu_pkg::LSCU_CMD_RBPTR_SET &&
            cmd_arg_i <= {6'h00, lscu_pkg::PTR_MAX}) begin
         rbptr_r <= cmd_arg_i[9:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         current_setpoint_r <= 16'h0000;
      end else if (cmd_valid_i && cmd_i == lscu_pkg::LSCU_CMD_CURRENT_SETPOINT_SET &&
            !(current_setpoint_quarter_i && cmd_arg_i > lscu_pkg::CURRENT_SETPOINT_QUARTER)) begin
         current_setpoint_r <= cmd_arg_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Table filling; excess values beyond capacity are dropped
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fill_r <= 11'h000;
      end else if (take && cmd_i == lscu_pkg::LSCU_CMD_CLEAR) begin
         fill_r <= 11'h000;
      end else if (take && cmd_i == lscu_pkg::LSCU_CMD_VOLT_ADD &&
            !volt_blk && fill_r < lscu_pkg::DATA_DEPTH) begin
         fill_r <= fill_r + 11'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         seqn_r <= 10'h000;
      end else if (take && cmd_i == lscu_pkg::LSCU_CMD_CLEAR) begin
         seqn_r <= 10'h000;
      end else if (take && cmd_i == lscu_pkg::LSCU_CMD_SEQ_ADD &&
            seqn_r < lscu_pkg::SEQ_DEPTH) begin
         seqn_r <= seqn_r + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Table port: writes, readback and step fetch
   always_comb begin
      tbl.we = 1'b0;
      tbl.sel_seq = 1'b0;
      tbl.waddr = fill_r[9:0];
      tbl.wdata = cmd_arg_i;
      if (take && cmd_i == lscu_pkg::LSCU_CMD_VOLT_ADD && !volt_blk &&
            fill_r < lscu_pkg::DATA_DEPTH) begin
         tbl.we = 1'b1;
      end else if (take && cmd_i == lscu_pkg::LSCU_CMD_SEQ_ADD &&
            seqn_r < lscu_pkg::SEQ_DEPTH) begin
         tbl.we = 1'b1;
         tbl.sel_seq = 1'b1;
         tbl.waddr = seqn_r;
      end
   end

   assign tbl.raddr = (st_r == LSCU_RB) ? rb_addr_r :
      (st_r == LSCU_MAP) ? tbl.rdata[9:0] : step_r;
   assign tbl.rsel_seq = (st_r == LSCU_RB) ? rb_seq_r :
      (st_r == LSCU_FETCH && custom_r);
   assign last_idx = custom_r ? seqn_r - 10'h001 : fill_r[9:0] - 10'h001;
   assign rb_lim = rb_seq_r ? {1'b0, seqn_r} : fill_r;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: readback bursts and list stepping
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_r <= LSCU_IDLE;
         rb_left_r <= 5'h00;
         rb_addr_r <= 10'h000;
         rb_seq_r <= 1'b0;
         rb_pend_r <= 1'b0;
         step_r <= 10'h000;
         running_r <= 1'b0;
         level_r <= 16'h0000;
         resp_r <= 16'h0000;
         resp_v_r <= 1'b0;
         resp_l_r <= 1'b0;
      end else begin
         resp_v_r <= 1'b0;
         resp_l_r <= 1'b0;
         rb_pend_r <= 1'b0;
         case (st_r)
            LSCU_IDLE: begin
               if (take) begin
                  case (cmd_i)
                     lscu_pkg::LSCU_CMD_ORDER_GET: begin
                        resp_r <= {15'h0000, custom_r};
                        resp_v_r <= 1'b1;
                        resp_l_r <= 1'b1;
                     end
                     lscu_pkg::LSCU_CMD_RBPTR_GET: begin
                        resp_r <= {6'h00, rbptr_r};
                        resp_v_r <= 1'b1;
                        resp_l_r <= 1'b1;
                     end
                     lscu_pkg::LSCU_CMD_VOLT_COUNT: begin
                        if (!volt_blk) begin
                           resp_r <= {5'h00, fill_r};
                           resp_v_r <= 1'b1;
                           resp_l_r <= 1'b1;
                        end
                     end
                     lscu_pkg::LSCU_CMD_SEQ_GET,
                     lscu_pkg::LSCU_CMD_VOLT_GET: begin
                        if (!volt_blk) begin
                           st_r <= LSCU_RB;
                           rb_addr_r <= rbptr_r;
                           rb_seq_r <= cmd_i == lscu_pkg::LSCU_CMD_SEQ_GET;
                           rb_left_r <= lscu_pkg::RB_COUNT;
                        end
                     end
                     lscu_pkg::LSCU_CMD_RUN: begin
                        if ((custom_r ? seqn_r : fill_r[9:0]) != 10'h000) begin
                           running_r <= 1'b1;
                           st_r <= LSCU_FETCH;
                           step_r <= dir_down_i ? last_idx : 10'h000;
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
            LSCU_RB: begin
               // Each word reads one cycle after its address is issued
               rb_pend_r <= ({1'b0, rb_addr_r} < rb_lim) && rb_left_r != 0;
               if ({1'b0, rb_addr_r} < rb_lim && rb_left_r != 0) begin
                  rb_addr_r <= rb_addr_r + 10'h001;
                  rb_left_r <= rb_left_r - 5'h01;
               end else if (!rb_pend_r) begin
                  st_r <= LSCU_IDLE;
               end
               if (rb_pend_r) begin
                  resp_r <= tbl.rdata;
                  resp_v_r <= 1'b1;
                  resp_l_r <= !(({1'b0, rb_addr_r} < rb_lim) &&
                     rb_left_r != 0);
               end
            end
            LSCU_FETCH: begin
               // Custom order reads the entry first, then its data word
               st_r <= custom_r ? LSCU_MAP : LSCU_LOAD;
            end
            LSCU_MAP: st_r <= LSCU_LOAD;
            LSCU_LOAD: begin
               level_r <= tbl.rdata;
               st_r <= LSCU_DATA;
            end
            LSCU_DATA: begin
               // Dwell pulses during the short fetch are not expected
               if (step_i) begin
                  if (step_r == (dir_down_i ? 10'h000 : last_idx)) begin
                     running_r <= 1'b0;
                     st_r <= LSCU_IDLE;
                  end else begin
                     step_r <= dir_down_i ? step_r - 10'h001 :
                        step_r + 10'h001;
                     st_r <= LSCU_FETCH;
                  end
               end
            end
            default: st_r <= LSCU_IDLE;
         endcase
         // A stop ends the run from any step phase
         if (running_r && cmd_valid_i &&
               cmd_i == lscu_pkg::LSCU_CMD_STOP) begin
            running_r <= 1'b0;
            st_r <= LSCU_IDLE;
         end
      end
   end

   // In natural order the fetch already addresses the data table
   assign custom_order_o = custom_r;
   assign rb_ptr_o = rbptr_r;
   assign fill_cnt_o = fill_r;
   assign seq_cnt_o = seqn_r;
   assign resp_data_o = resp_r;
   assign resp_valid_o = resp_v_r;
   assign resp_last_o = resp_l_r;
   assign err_code_o = err_r;
   assign err_valid_o = err_v_r;
   assign current_setpoint_set_o = current_setpoint_r;
   assign level_o = level_r;
   assign running_o = running_r;

   ////////////////////////////////////////////////////////////////////////
   property p_conflict;
      @(posedge clk_i) disable iff (!rst_n_i)
      take && volt_blk |=> err_v_r && err_r == lscu_pkg::ERR_CONFLICT;
   endproperty
   a_conflict: assert property (p_conflict)
      else $error("conflict error missing");
   property p_range;
      @(posedge clk_i) disable iff (!rst_n_i)
      cmd_valid_i && cmd_i == lscu_pkg::LSCU_CMD_CURRENT_SETPOINT_SET && current_setpoint_quarter_i
      && cmd_arg_i > lscu_pkg::CURRENT_SETPOINT_QUARTER |=> $stable(current_setpoint_r) && err_v_r;
   endproperty
   a_range: assert property (p_range)
      else $error("quarter range setpoint accepted");
   property p_clear;
      @(posedge clk_i) disable iff (!rst_n_i)
      take && cmd_i == lscu_pkg::LSCU_CMD_CLEAR |=> fill_r == 11'h000;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear left fill pointer");
   property p_fill_cap;
      @(posedge clk_i) disable iff (!rst_n_i)
      fill_r <= lscu_pkg::DATA_DEPTH && seqn_r <= lscu_pkg::SEQ_DEPTH;
   endproperty
   a_fill_cap: assert property (p_fill_cap)
      else $error("table over capacity");
   property p_append;
      @(posedge clk_i) disable iff (!rst_n_i)
      tbl.we && !tbl.sel_seq |=> fill_r == $past(fill_r) + 11'h001;
   endproperty
   a_append: assert property (p_append)
      else $error("fill pointer did not count");
   property p_busy;
      @(posedge clk_i) disable iff (!rst_n_i)
      running_r && cfg_cmd |=> err_r == lscu_pkg::ERR_COMMAND;
   endproperty
   a_busy: assert property (p_busy)
      else $error("config accepted while running");
   property p_rbptr;
      @(posedge clk_i) disable iff (!rst_n_i)
      rbptr_r <= lscu_pkg::PTR_MAX;
   endproperty
   a_rbptr: assert property (p_rbptr)
      else $error("readback pointer out of range");
   property p_burst;
      @(posedge clk_i) disable iff (!rst_n_i)
      take && cmd_i == lscu_pkg::LSCU_CMD_SEQ_GET |->
         ##[1:20] st_r == LSCU_IDLE;
   endproperty
   a_burst: assert property (p_burst)
      else $error("readback burst too long");
   c_run: cover property (@(posedge clk_i) running_r && custom_r);
   c_rb: cover property (@(posedge clk_i) resp_v_r && resp_l_r);
   c_err: cover property (@(posedge clk_i) err_v_r);
endmodule // lscu_top

/* tb/lscu_host.sv */
// Host model: sends one parsed command value per strobe
`timescale 1ns/10ps
module lscu_host (
   input wire logic clk_i,                 // Bench clock
   output lscu_pkg::lscu_cmd_t cmd_o,      // Command code
   output logic valid_o,                   // Command strobe
   output logic [15:0] arg_o               // Command argument
);
   int seq_sent;
   initial begin
      cmd_o = lscu_pkg::LSCU_CMD_NONE;
      valid_o = 1'b0;
      arg_o = 16'h0000;
      seq_sent = 0;
   end
   // One value per strobe keeps every message far below the limit
   task automatic send(input lscu_pkg::lscu_cmd_t c, input logic [15:0] a,
      input bit over);
      if (c == lscu_pkg::LSCU_CMD_CLEAR) seq_sent = 0;
      // Legacy entry command, used only where a test needs it
      if (c == lscu_pkg::LSCU_CMD_SEQ_ADD) seq_sent++;
      // Capacity is overrun only when a test asks for it
      if (c == lscu_pkg::LSCU_CMD_SEQ_ADD && seq_sent > 512 && !over) return;
      cmd_o = c;
      arg_o = a;
      valid_o = 1'b1;
      @(negedge clk_i);
   endtask
   task automatic idle();
      valid_o = 1'b0;
      cmd_o = lscu_pkg::LSCU_CMD_NONE;
   endtask
endmodule // lscu_host

/* tb/tb.sv */
// Self-checking bench of the list sequence command unit
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   lscu_pkg::lscu_cmd_t cmd;
   logic cmd_valid;
   logic [15:0] cmd_arg;
   logic current_setpoint_used = 1'b0;
   logic quarter = 1'b0;
   logic dir_down = 1'b0;
   logic step = 1'b0;
   logic custom_order, resp_valid, resp_last, err_valid, running;
   logic [9:0] rb_ptr, seq_cnt;
   logic [10:0] fill_cnt;
   logic [15:0] resp_data, err_code, current_setpoint_set, level;
   int n_errors = 0;
   int total_checks = 0;
   int n_last;
   logic [15:0] rx[$];
   logic [15:0] err;
   logic [15:0] sq[5] = '{16'h0003, 16'h0003, 16'h0000, 16'h0013, 16'h0001};
   typedef lscu_pkg::lscu_cmd_t lscu_c_t;
   always #10 clk = ~clk;
   lscu_host host (.clk_i(clk), .cmd_o(cmd), .valid_o(cmd_valid),
      .arg_o(cmd_arg));
   lscu_top dut (.clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd),
      .cmd_valid_i(cmd_valid), .cmd_arg_i(cmd_arg),
      .current_setpoint_list_used_i(current_setpoint_used), .current_setpoint_quarter_i(quarter),
      .dir_down_i(dir_down), .step_i(step), .custom_order_o(custom_order),
      .rb_ptr_o(rb_ptr), .fill_cnt_o(fill_cnt), .seq_cnt_o(seq_cnt),
      .resp_data_o(resp_data), .resp_valid_o(resp_valid),
      .resp_last_o(resp_last), .err_code_o(err_code), .err_valid_o(err_valid),
      .current_setpoint_set_o(current_setpoint_set), .level_o(level), .running_o(running));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] vexp(input int i);
      return 16'h0a00 + 16'(i);
   endfunction
   task automatic chk(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      if (n_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Sends a command and gathers every word and error of its answer
   task automatic ask(input lscu_c_t c, input logic [15:0] a);
      rx.delete();
      err = 16'h0000;
      n_last = 0;
      host.send(c, a, 1'b0);
      host.idle();
      for (int i = 0; i < 24; i++) begin
         if (resp_valid === 1'b1) rx.push_back(resp_data);
         if (err_valid === 1'b1) err = err_code;
         if (resp_last === 1'b1) n_last++;
         @(negedge clk);
      end
   endtask
   task automatic chk_rb(input int n, input int base, input bit is_seq);
      chk("words", 16'(rx.size()), 16'(n));
      chk("last", 16'(n_last), 16'(n > 0));
      for (int i = 0; i < n && i < rx.size(); i++) begin
         chk("word", rx[i], is_seq ? sq[base + i] : vexp(base + i));
      end
   endtask
   task automatic run_chk(input bit cust, input bit down,
      input logic [15:0] e0, input logic [15:0] e1);
      ask(lscu_pkg::LSCU_CMD_ORDER_SET, {15'h0000, cust});
      dir_down = down;
      ask(lscu_pkg::LSCU_CMD_RUN, 16'h0000);
      chk("running", {15'h0000, running}, 16'h0001);
      chk("level0", level, e0);
      step = 1'b1;
      @(negedge clk);
      step = 1'b0;
      repeat (4) @(negedge clk);
      chk("level1", level, e1);
      ask(lscu_pkg::LSCU_CMD_ORDER_SET, {15'h0000, ~cust});
      chk("run_err", err, lscu_pkg::ERR_COMMAND);
      chk("order_kept", 16'(custom_order), 16'(cust));
      ask(lscu_pkg::LSCU_CMD_STOP, 16'h0000);
      chk("stopped", {15'h0000, running}, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      chk("fill_rst", 16'(fill_cnt), 16'h0000);
      chk("ptr_rst", {6'h00, rb_ptr}, 16'h0000);
      for (int k = 1; k >= 0; k--) begin
         ask(lscu_pkg::LSCU_CMD_ORDER_SET, 16'(k));
         chk("order", {15'h0000, custom_order}, 16'(k));
         ask(lscu_pkg::LSCU_CMD_ORDER_GET, 16'h0000);
         chk("order_q", rx.size() > 0 ? rx[0] : 16'hdead, 16'(k));
      end
      // Appends go back to back, one strobe per value
      for (int i = 0; i < 20; i++) host.send(lscu_pkg::LSCU_CMD_VOLT_ADD,
         vexp(i), 1'b0);
      host.idle();
      repeat (3) @(negedge clk);
      chk("fill", 16'(fill_cnt), 16'h0014);
      ask(lscu_pkg::LSCU_CMD_VOLT_COUNT, 16'h0000);
      chk("count_n", 16'(rx.size()), 16'h0001);
      chk("count_last", 16'(n_last), 16'h0001);
      chk("count", rx.size() > 0 ? rx[0] : 16'hdead, 16'h0014);
      ask(lscu_pkg::LSCU_CMD_VOLT_GET, 16'h0000);
      chk_rb(16, 0, 1'b0);
      ask(lscu_pkg::LSCU_CMD_RBPTR_SET, 16'h0010);
      ask(lscu_pkg::LSCU_CMD_RBPTR_GET, 16'h0000);
      chk("ptr_q", rx.size() > 0 ? rx[0] : 16'hdead, 16'h0010);
      ask(lscu_pkg::LSCU_CMD_VOLT_GET, 16'h0000);
      chk_rb(4, 16, 1'b0);
      ask(lscu_pkg::LSCU_CMD_RBPTR_SET, 16'h03ea);
      chk("ptr_err", err, lscu_pkg::ERR_RANGE);
      chk("ptr_kept", {6'h00, rb_ptr}, 16'h0010);
      ask(lscu_pkg::LSCU_CMD_RBPTR_SET, 16'h03e9);
      chk("ptr_max", {6'h00, rb_ptr}, 16'h03e9);
      ask(lscu_pkg::LSCU_CMD_VOLT_GET, 16'h0000);
      chk_rb(0, 0, 1'b0);
      ask(lscu_pkg::LSCU_CMD_RBPTR_SET, 16'h0000);
      for (int i = 0; i < 5; i++) host.send(lscu_pkg::LSCU_CMD_SEQ_ADD,
         sq[i], 1'b0);
      host.idle();
      repeat (3) @(negedge clk);
      chk("seq_cnt", {6'h00, seq_cnt}, 16'h0005);
      ask(lscu_pkg::LSCU_CMD_SEQ_GET, 16'h0000);
      chk_rb(5, 0, 1'b1);
      current_setpoint_used = 1'b1;
      for (int k = 0; k < 3; k++) begin
         ask(k == 0 ? lscu_pkg::LSCU_CMD_VOLT_ADD : k == 1 ?
            lscu_pkg::LSCU_CMD_VOLT_GET : lscu_pkg::LSCU_CMD_VOLT_COUNT,
            16'h0001);
         chk("conflict", err, lscu_pkg::ERR_CONFLICT);
         chk("conf_words", 16'(rx.size()), 16'h0000);
      end
      chk("fill_kept", 16'(fill_cnt), 16'h0014);
      current_setpoint_used = 1'b0;
      quarter = 1'b1;
      ask(lscu_pkg::LSCU_CMD_CURRENT_SETPOINT_SET, 16'h3fff);
      chk("current_setpoint_q", current_setpoint_set, 16'h3fff);
      ask(lscu_pkg::LSCU_CMD_CURRENT_SETPOINT_SET, 16'h4000);
      chk("current_setpoint_err", err, lscu_pkg::ERR_RANGE);
      chk("current_setpoint_kept", current_setpoint_set, 16'h3fff);
      quarter = 1'b0;
      ask(lscu_pkg::LSCU_CMD_CURRENT_SETPOINT_SET, 16'h8000);
      chk("current_setpoint_full", current_setpoint_set, 16'h8000);
      run_chk(1'b0, 1'b0, vexp(0), vexp(1));
      run_chk(1'b0, 1'b1, vexp(19), vexp(18));
      run_chk(1'b1, 1'b0, vexp(3), vexp(3));
      run_chk(1'b1, 1'b1, vexp(1), vexp(19));
      dir_down = 1'b0;
      // One value beyond capacity is sent on purpose and must be dropped
      for (int i = 5; i < 513; i++) host.send(lscu_pkg::LSCU_CMD_SEQ_ADD,
         16'h0002, 1'b1);
      host.idle();
      repeat (3) @(negedge clk);
      chk("seq_full", {6'h00, seq_cnt}, 16'h0200);
      ask(lscu_pkg::LSCU_CMD_CLEAR, 16'h0000);
      chk("fill_clr", 16'(fill_cnt), 16'h0000);
      ask(lscu_pkg::LSCU_CMD_VOLT_COUNT, 16'h0000);
      chk("count_clr", rx.size() > 0 ? rx[0] : 16'hdead, 16'h0000);
      end_sim();
   end
endmodule // tb
